// file: rtl/tope_pkg.sv
// package: register map, field layout and types of the one-pulse / encoder timer
package tope_pkg;

  localparam int          TOPE_CNT_W         = 16;
  localparam int          TOPE_AW            = 8;

  // register byte offsets
  localparam logic [7:0]  TOPE_OFS_CTRL      = 8'h00;
  localparam logic [7:0]  TOPE_OFS_SLAVE     = 8'h04;
  localparam logic [7:0]  TOPE_OFS_CHAN      = 8'h08;
  localparam logic [7:0]  TOPE_OFS_COUNT     = 8'h0c;
  localparam logic [7:0]  TOPE_OFS_RELOAD    = 8'h10;
  localparam logic [7:0]  TOPE_OFS_COMPARE   = 8'h14;
  localparam logic [7:0]  TOPE_OFS_EVENT     = 8'h18;

  // control register fields
  localparam int          TOPE_CTRL_RUN      = 0;
  localparam int          TOPE_CTRL_SHOT     = 1;
  localparam int          TOPE_CTRL_DIR      = 2;
  localparam int          TOPE_CTRL_RLBE     = 3;
  // slave register fields
  localparam int          TOPE_SLV_SMS_LSB   = 0;
  localparam int          TOPE_SLV_TS_LSB    = 4;
  // channel register fields
  localparam int          TOPE_CH_MODE_LSB   = 0;
  localparam int          TOPE_CH_FAST       = 3;
  localparam int          TOPE_CH_CBE        = 4;
  localparam int          TOPE_CH_POLA       = 5;
  localparam int          TOPE_CH_POLB       = 6;
  localparam int          TOPE_CH_OUTPOL     = 7;
  // event register
  localparam int          TOPE_EV_UG         = 0;

  localparam logic [2:0]  TOPE_SMS_ENC_B     = 3'h1;
  localparam logic [2:0]  TOPE_SMS_ENC_A     = 3'h2;
  localparam logic [2:0]  TOPE_SMS_ENC_AB    = 3'h3;
  localparam logic [2:0]  TOPE_SMS_TRIGGER   = 3'h6;
  localparam logic [2:0]  TOPE_TS_FILT_B     = 3'h6;
  localparam logic [2:0]  TOPE_TS_FILT_A     = 3'h5;

  localparam logic [2:0]  TOPE_OCM_PWM1      = 3'h6;
  localparam logic [2:0]  TOPE_OCM_PWM2      = 3'h7;

  localparam logic [15:0] TOPE_RELOAD_RST    = 16'hffff;

  typedef enum logic [1:0] {
    TOPE_HTRANS_IDLE   = 2'b00,
    TOPE_HTRANS_BUSY   = 2'b01,
    TOPE_HTRANS_NONSEQ = 2'b10,
    TOPE_HTRANS_SEQ    = 2'b11
  } tope_htrans_e;

  typedef enum logic [0:0] {
    TOPE_BUS_ADDR = 1'b0,
    TOPE_BUS_DATA = 1'b1
  } tope_bus_e;

  typedef struct packed {
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } tope_ahb_req_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } tope_ahb_rsp_s;

endpackage : tope_pkg

// file: rtl/tope_timer.sv
// one-pulse and encoder timer with an AHB-Lite register slave
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps

module tope_timer
  import tope_pkg::*;
#(
  parameter int CNT_W = TOPE_CNT_W
)(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire tope_ahb_req_s ahb_i,
  output tope_ahb_rsp_s      ahb_o,
  input  wire logic          quadrature_in_a_i,
  input  wire logic          quadrature_in_b_i,
  output logic               reference_waveform_o,
  output logic               channel_output_o,
  output logic               count_direction_bit_o
);

  // the register map and shadows are laid out for a 16-bit count only
  if (CNT_W != TOPE_CNT_W)
  begin : g_bad_width
    $error("tope_timer: only a 16-bit counter is supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic        prev_a;
    logic        prev_b;
    logic        counter_run_bit;
    logic        single_shot_select;
    logic        count_direction_bit;
    logic        reload_buffer_enable;
    logic [2:0]  slave_mode_field;
    logic [2:0]  trigger_source_field;
    logic [2:0]  compare_mode_field;
    logic        fast_output_enable;
    logic        compare_buffer_enable;
    logic        polarity_in_a;
    logic        polarity_in_b;
    logic        out_polarity;
    logic [15:0] count_value;
    logic [15:0] reload_value;
    logic [15:0] reload_shadow;
    logic [15:0] compare_value;
    logic [15:0] compare_shadow;
    logic        reference_waveform;
    logic        channel_output;
    tope_bus_e   bus_phase;
    logic        bus_wr;
    logic [7:0]  bus_addr;
    logic        bus_ready;
    logic [31:0] rdata;
  } tope_state_s;

  tope_state_s st;
  tope_state_s next_st;

  logic        filt_a;
  logic        filt_b;
  logic        edge_a;
  logic        edge_b;
  logic        trig_edge;
  logic        trig_sel;
  logic        enc_mode;
  logic        enc_step;
  logic        enc_up;
  logic        tick;
  logic        at_wrap;
  logic        update_ev;
  logic        pwm_mode;
  logic [31:0] rd_mux;
  logic [31:0] wd;

  // polarity applied after the second sync stage only
  assign filt_a   = st.sync_a[1] ^ st.polarity_in_a;
  assign filt_b   = st.sync_b[1] ^ st.polarity_in_b;
  assign edge_a   = filt_a != st.prev_a;
  assign edge_b   = filt_b != st.prev_b;
  assign enc_mode = st.slave_mode_field inside {TOPE_SMS_ENC_B, TOPE_SMS_ENC_A,
                                                TOPE_SMS_ENC_AB};
  assign pwm_mode = st.compare_mode_field inside {TOPE_OCM_PWM1, TOPE_OCM_PWM2};

  // trigger input: filtered b (or a) rising edge
  always_comb
  begin
    trig_edge = 1'b0;
    if (st.trigger_source_field == TOPE_TS_FILT_B)
      trig_edge = edge_b & filt_b;
    else if (st.trigger_source_field == TOPE_TS_FILT_A)
      trig_edge = edge_a & filt_a;
  end
  assign trig_sel = (st.slave_mode_field == TOPE_SMS_TRIGGER) & trig_edge;

  // quadrature decode; simultaneous change is ignored as a glitch
  always_comb
  begin
    enc_step = 1'b0;
    enc_up   = 1'b0;
    if (edge_a & ~edge_b)
    begin
      enc_up   = filt_a ^ filt_b;
      enc_step = st.slave_mode_field != TOPE_SMS_ENC_B;
    end
    else if (edge_b & ~edge_a)
    begin
      enc_up   = ~(filt_a ^ filt_b);
      enc_step = st.slave_mode_field != TOPE_SMS_ENC_A;
    end
  end

  assign tick      = enc_mode ? (st.counter_run_bit & enc_step) : st.counter_run_bit;
  assign at_wrap   = (enc_mode ? enc_up : ~st.count_direction_bit)
                     ? (st.count_value == st.reload_shadow)
                     : (st.count_value == 16'h0000);
  assign update_ev = tick & at_wrap;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (st.bus_addr)
      TOPE_OFS_CTRL:    rd_mux = {28'h0000000, st.reload_buffer_enable,
                                  st.count_direction_bit, st.single_shot_select,
                                  st.counter_run_bit};
      TOPE_OFS_SLAVE:   rd_mux = {25'h0000000, st.trigger_source_field, 1'b0,
                                  st.slave_mode_field};
      TOPE_OFS_CHAN:    rd_mux = {24'h000000, st.out_polarity, st.polarity_in_b,
                                  st.polarity_in_a, st.compare_buffer_enable,
                                  st.fast_output_enable, st.compare_mode_field};
      TOPE_OFS_COUNT:   rd_mux = {16'h0000, st.count_value};
      TOPE_OFS_RELOAD:  rd_mux = {16'h0000, st.reload_value};
      TOPE_OFS_COMPARE: rd_mux = {16'h0000, st.compare_value};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  assign wd = ahb_i.hwdata;

  always_comb
  begin
    next_st        = st;
    next_st.sync_a = {st.sync_a[0], quadrature_in_a_i};
    next_st.sync_b = {st.sync_b[0], quadrature_in_b_i};
    next_st.prev_a = filt_a;
    next_st.prev_b = filt_b;

    // counting; encoder wraps both ways inside zero..reload
    if (tick)
    begin
      if (enc_mode ? enc_up : ~st.count_direction_bit)
        next_st.count_value = at_wrap ? 16'h0000 : st.count_value + 16'h0001;
      else
        next_st.count_value = at_wrap ? st.reload_shadow : st.count_value - 16'h0001;
    end
    if (enc_mode & (edge_a ^ edge_b))
      next_st.count_direction_bit = ~enc_up;

    if (update_ev)
    begin
      next_st.reload_shadow  = st.reload_value;
      next_st.compare_shadow = st.compare_value;
      if (st.single_shot_select)
        next_st.counter_run_bit = 1'b0;
    end
    if (!st.reload_buffer_enable)
      next_st.reload_shadow = st.reload_value;
    if (!st.compare_buffer_enable)
      next_st.compare_shadow = st.compare_value;

    // trigger starts the counter
    if (trig_sel & ~enc_mode)
      next_st.counter_run_bit = 1'b1;

    // reference: pwm2 rises on match, falls at reload; pwm1 inverted
    if (pwm_mode)
    begin
      if (st.count_value == st.compare_shadow && st.count_value != st.reload_shadow)
        next_st.reference_waveform = st.compare_mode_field == TOPE_OCM_PWM2;
      else if (st.count_value == st.reload_shadow && tick)
        next_st.reference_waveform = st.compare_mode_field != TOPE_OCM_PWM2;
      if (trig_sel & st.fast_output_enable)
        next_st.reference_waveform = st.compare_mode_field == TOPE_OCM_PWM2;
    end

    // AHB-Lite slave, zero wait states on writes, one wait state on reads
    if (ahb_i.hready)
    begin
      next_st.bus_phase = (ahb_i.hsel & ahb_i.htrans[1]) ? TOPE_BUS_DATA : TOPE_BUS_ADDR;
      next_st.bus_wr    = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hwrite;
      next_st.bus_addr  = ahb_i.haddr;
    end
    if (st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    begin
      case (st.bus_addr)
        TOPE_OFS_CTRL:
        begin
          next_st.counter_run_bit      = wd[TOPE_CTRL_RUN];
          next_st.single_shot_select   = wd[TOPE_CTRL_SHOT];
          next_st.reload_buffer_enable = wd[TOPE_CTRL_RLBE];
          if (!enc_mode)
            next_st.count_direction_bit = wd[TOPE_CTRL_DIR];
        end
        TOPE_OFS_SLAVE:
        begin
          next_st.slave_mode_field     = wd[TOPE_SLV_SMS_LSB +: 3];
          next_st.trigger_source_field = wd[TOPE_SLV_TS_LSB +: 3];
        end
        TOPE_OFS_CHAN:
        begin
          next_st.compare_mode_field    = wd[TOPE_CH_MODE_LSB +: 3];
          next_st.fast_output_enable    = wd[TOPE_CH_FAST];
          next_st.compare_buffer_enable = wd[TOPE_CH_CBE];
          next_st.polarity_in_a         = wd[TOPE_CH_POLA];
          next_st.polarity_in_b         = wd[TOPE_CH_POLB];
          next_st.out_polarity          = wd[TOPE_CH_OUTPOL];
        end
        TOPE_OFS_COUNT:   next_st.count_value   = wd[15:0];
        TOPE_OFS_RELOAD:  next_st.reload_value  = wd[15:0];
        TOPE_OFS_COMPARE: next_st.compare_value = wd[15:0];
        TOPE_OFS_EVENT:
        begin
          // update generate: reinit counter and load shadows
          if (wd[TOPE_EV_UG])
          begin
            next_st.count_value    = 16'h0000;
            next_st.reload_shadow  = st.reload_value;
            next_st.compare_shadow = st.compare_value;
            // level compare at zero, so a stale reference cannot survive the reinit
            if (pwm_mode)
              next_st.reference_waveform = (st.compare_mode_field == TOPE_OCM_PWM2)
                                           == (st.compare_value == 16'h0000);
          end
        end
        default: ;
      endcase
    end
    // reads take one wait state: hrdata leaves a flop and sees a write just landed
    if (ahb_i.hready & ahb_i.hsel & ahb_i.htrans[1] & ~ahb_i.hwrite)
      next_st.bus_ready = 1'b0;
    if (st.bus_phase == TOPE_BUS_DATA && !st.bus_wr && !st.bus_ready)
    begin
      next_st.rdata     = rd_mux;
      next_st.bus_ready = 1'b1;
    end
    next_st.channel_output = next_st.reference_waveform ^ st.out_polarity;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st              <= '0;
      st.reload_value <= TOPE_RELOAD_RST;
      st.reload_shadow <= TOPE_RELOAD_RST;
      st.bus_ready     <= 1'b1;
    end
    else if (ce_i)
      st <= next_st;
  end

  assign ahb_o.hreadyout = st.bus_ready;
  assign ahb_o.hresp     = 1'b0;
  assign ahb_o.hrdata    = st.rdata;

  assign reference_waveform_o  = st.reference_waveform;
  assign channel_output_o      = st.channel_output;
  assign count_direction_bit_o = st.count_direction_bit;

  ////////////////////////////////////////////////////////////////////////////
  AST_SHOT_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && update_ev && st.single_shot_select && !trig_sel
    && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr) |=> !st.counter_run_bit)
    else $error("single shot did not stop at update");
  AST_TRIG_START: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trig_sel && !enc_mode && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    |=> st.counter_run_bit)
    else $error("trigger did not start counter");
  AST_FAST_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trig_sel && st.fast_output_enable && st.compare_mode_field == TOPE_OCM_PWM2
    && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    |=> reference_waveform_o)
    else $error("fast enable did not force reference");
  AST_FAST_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pwm_mode |=> $stable(reference_waveform_o))
    else $error("reference moved outside pwm modes");
  AST_NO_DOUBLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enc_mode && edge_a && edge_b && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    |=> $stable(count_direction_bit_o) && $stable(st.count_value))
    else $error("double edge changed encoder state");
  AST_ENC_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enc_mode && tick && st.count_value <= st.reload_shadow
    && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    |=> st.count_value <= $past(st.reload_shadow))
    else $error("encoder count left range");
  AST_ENC_ONLY_B: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st.slave_mode_field == TOPE_SMS_ENC_B && edge_a && !edge_b
    && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr) |=> $stable(st.count_value))
    else $error("a edge counted in b-only mode");
  AST_DIR_A: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enc_mode && edge_a && !edge_b && filt_a && filt_b |=> count_direction_bit_o)
    else $error("a rise with b high not down");
  AST_DIR_B: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && enc_mode && edge_b && !edge_a && filt_a && filt_b |=> !count_direction_bit_o)
    else $error("b rise with a high not up");
  AST_OUT_POL: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr)
    |=> channel_output_o == (reference_waveform_o ^ st.out_polarity))
    else $error("channel output not reference with polarity");

  COV_TRIG: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && trig_sel);
  COV_SHOT: cover property (@(posedge clk_i) disable iff (rst_i)
    update_ev && st.single_shot_select);
  COV_ENC_UP: cover property (@(posedge clk_i) disable iff (rst_i) enc_mode && tick && enc_up);
  COV_ENC_DN: cover property (@(posedge clk_i) disable iff (rst_i) enc_mode && tick && !enc_up);
  COV_FAST: cover property (@(posedge clk_i) disable iff (rst_i)
    trig_sel && st.fast_output_enable && pwm_mode);

  AST_PULSE_END: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st.compare_mode_field == TOPE_OCM_PWM2 && tick
    && st.count_value == st.reload_shadow && !(trig_sel && st.fast_output_enable)
    && !(st.bus_phase == TOPE_BUS_DATA && st.bus_wr) |=> !reference_waveform_o)
    else $error("reference did not fall at reload");
  AST_READ_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ahb_i.hready && ahb_i.hsel && ahb_i.htrans[1] && !ahb_i.hwrite
    |=> !ahb_o.hreadyout)
    else $error("read address phase not followed by a wait state");
  AST_READ_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ahb_o.hreadyout |=> ahb_o.hreadyout)
    else $error("read wait state lasted more than one cycle");

endmodule // tope_timer

// file: sim/tope_quad_src.sv
// partner model: incremental encoder and trigger source driving both inputs
`timescale 1ns/1ps
module tope_quad_src (
  input  wire logic clk_i,
  output logic      a_o,
  output logic      b_o
);
  initial
  begin
    a_o = 1'b0;
    b_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // levels change only right after an edge and then stand until the next move
  task automatic move(input bit ta, input bit tb);
    @(posedge clk_i);
    a_o <= a_o ^ ta;
    b_o <= b_o ^ tb;
  endtask
endmodule // tope_quad_src

// file: sim/timer_one_pulse_encoder_tb_top.sv
// testbench: bus master, encoder model and one-shot checks for the timer
`timescale 1ns/1ps
module timer_one_pulse_encoder_tb_top;
  import tope_pkg::*;
  localparam int RL = 9;
  logic          clk_i;
  logic          rst_i;
  tope_ahb_req_s req;
  tope_ahb_req_s bus;
  tope_ahb_rsp_s rsp;
  logic          qa;
  logic          qb;
  logic          ref_w;
  logic          chan_w;
  logic          dir_w;
  int            n_errors;
  int            checked;
  int            cnt;
  int            rl;
  bit            exp_dir;
  logic [2:0]    sms;
  bit            pa;
  bit            pb;

  always_comb
  begin
    bus        = req;
    bus.hready = rsp.hreadyout;
  end

  tope_timer DUT (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .ce_i                  (1'b1),
    .ahb_i                 (bus),
    .ahb_o                 (rsp),
    .quadrature_in_a_i     (qa),
    .quadrature_in_b_i     (qb),
    .reference_waveform_o  (ref_w),
    .channel_output_o      (chan_w),
    .count_direction_bit_o (dir_w)
  );
  tope_quad_src src (
    .clk_i (clk_i),
    .a_o   (qa),
    .b_o   (qb)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask

  // sample just before the edge so the slave's own update cannot race us
  task automatic phase(output logic [31:0] d);
    int   g;
    logic r;
    g = 0;
    do
    begin
      @(negedge clk_i);
      r = rsp.hreadyout;
      d = rsp.hrdata;
      @(posedge clk_i);
      g++;
    end
    while (r !== 1'b1 && g < 50);
    if (r !== 1'b1)
    begin
      n_errors++;
      $display("Error hready expected 1 seen %b", r);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [31:0] d;
    @(posedge clk_i);
    req.hsel   <= 1'b1;
    req.haddr  <= a;
    req.htrans <= TOPE_HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    phase(d);
    req.htrans <= TOPE_HTRANS_IDLE;
    req.hwdata <= wd;
    phase(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(what, e, x);
    chk("response", 32'h0, {31'h0, rsp.hresp});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic step(input bit ta, input bit tb);
    bit fa;
    bit fb;
    bit dn;
    bit hit;
    fa  = qa ^ pa;
    fb  = qb ^ pb;
    dn  = 1'b0;
    hit = 1'b0;
    if (ta && !tb)
    begin
      dn      = ((fa ^ ta) == fb);
      hit     = (sms != TOPE_SMS_ENC_B);
      exp_dir = dn;
    end
    if (tb && !ta)
    begin
      dn      = ((fb ^ tb) != fa);
      hit     = (sms != TOPE_SMS_ENC_A);
      exp_dir = dn;
    end
    if (hit)
      cnt = dn ? ((cnt == 0) ? rl : cnt - 1) : ((cnt == rl) ? 0 : cnt + 1);
    src.move(ta, tb);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("direction", {31'h0, exp_dir}, {31'h0, dir_w});
    rdc("count", TOPE_OFS_COUNT, 32'(cnt));
  endtask

  task automatic enc(input logic [2:0] m, input bit ia, input bit ib, input int n);
    int i;
    int r;
    sms = m;
    pa  = ia;
    pb  = ib;
    rl  = 5;
    wr(TOPE_OFS_SLAVE, 32'h0);
    wr(TOPE_OFS_CTRL, 32'h0);
    wr(TOPE_OFS_RELOAD, 32'h5);
    wr(TOPE_OFS_CHAN, {25'h0, ib, ia, 5'h0});
    wr(TOPE_OFS_EVENT, 32'h1);
    wr(TOPE_OFS_SLAVE, {29'h0, m});
    wr(TOPE_OFS_CTRL, 32'h1);
    cnt     = 0;
    exp_dir = 1'b0;
    for (i = 0; i < n; i++)
    begin
      r = $urandom % 8;
      // code 6 moves both lines at once
      step(r < 3 || r > 5, r > 2 && r < 7);
    end
  endtask

  task automatic pulse(input logic [2:0] ts, input logic [2:0] m, input bit f, input bit op,
                       input logic [15:0] c, output int dly, output int len);
    // stop the counter first, else it free-runs and leaves the reference high
    wr(TOPE_OFS_CTRL, 32'h0);
    src.move(qa, qb);
    repeat (4) @(posedge clk_i);
    wr(TOPE_OFS_SLAVE, {25'h0, ts, 1'b0, TOPE_SMS_TRIGGER});
    wr(TOPE_OFS_CHAN, {24'h0, op, 3'h0, f, m});
    wr(TOPE_OFS_RELOAD, 32'(RL));
    wr(TOPE_OFS_COMPARE, {16'h0, c});
    wr(TOPE_OFS_EVENT, 32'h1);
    wr(TOPE_OFS_CTRL, 32'h2);
    src.move(ts == TOPE_TS_FILT_A, ts == TOPE_TS_FILT_B);
    dly = 0;
    len = 0;
    while (ref_w !== 1'b1 && dly < 60)
    begin
      @(negedge clk_i);
      dly++;
    end
    if (ref_w === 1'b1)
      chk("channel", {31'h0, ~op}, {31'h0, chan_w});
    while (ref_w === 1'b1 && len < 60)
    begin
      @(negedge clk_i);
      len++;
    end
    repeat (4) @(negedge clk_i);
    rdc("run", TOPE_OFS_CTRL, 32'h2);
    rdc("count", TOPE_OFS_COUNT, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole run is near 1700 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end

  initial
  begin
    int d2, l2, d5, l5, df, lf, dz, lz;
    req      = '0;
    rst_i    = 1'b1;
    n_errors = 0;
    checked  = 0;
    void'($urandom(75316));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("ctrl", TOPE_OFS_CTRL, 32'h0);
    rdc("reload", TOPE_OFS_RELOAD, {16'h0, TOPE_RELOAD_RST});
    rdc("compare", TOPE_OFS_COMPARE, 32'h0);
    wr(8'h1c, 32'h5a5a);
    rdc("unmapped", 8'h1c, 32'h0);
    enc(TOPE_SMS_ENC_AB, 1'b0, 1'b0, 24);
    enc(TOPE_SMS_ENC_B, 1'b0, 1'b0, 24);
    enc(TOPE_SMS_ENC_A, 1'b0, 1'b0, 24);
    enc(TOPE_SMS_ENC_AB, 1'b1, 1'b0, 24);
    enc(TOPE_SMS_ENC_AB, 1'b0, 1'b1, 24);
    pulse(TOPE_TS_FILT_B, TOPE_OCM_PWM2, 1'b0, 1'b0, 16'h2, d2, l2);
    pulse(TOPE_TS_FILT_B, TOPE_OCM_PWM2, 1'b0, 1'b1, 16'h5, d5, l5);
    pulse(TOPE_TS_FILT_A, TOPE_OCM_PWM2, 1'b1, 1'b1, 16'h5, df, lf);
    pulse(TOPE_TS_FILT_B, 3'h0, 1'b1, 1'b0, 16'h5, dz, lz);
    chk("delay step", 32'h3, 32'(d5 - d2));
    chk("length step", 32'h3, 32'(l2 - l5));
    chk("length", 32'(RL - 5), 32'(l5));
    chk("fast delay", 32'h1, 32'(df < d5));
    chk("frozen", 32'd60, 32'(dz));
    end_of_test();
  end
endmodule // timer_one_pulse_encoder_tb_top
